//--- hdl/dso_pkg.sv
// Purpose: Shared constants and types for the drive status output logic.
// Assumes: 32-bit APB data, one aligned word per register.
// Notes:   Speeds are signed rpm, widths and torque levels are in tenths of a percent.
package dso_pkg;

  // Register byte offsets.
  localparam logic [7:0] OFF_SEL_AB    = 8'h00;
  localparam logic [7:0] OFF_SEL_CR    = 8'h04;
  localparam logic [7:0] OFF_SPD_LVL1  = 8'h08;
  localparam logic [7:0] OFF_SPD_LVL2  = 8'h0C;
  localparam logic [7:0] OFF_SPD_LVL3  = 8'h10;
  localparam logic [7:0] OFF_METHOD    = 8'h14;
  localparam logic [7:0] OFF_ARR_WIDTH = 8'h18;
  localparam logic [7:0] OFF_AGR_WIDTH = 8'h1C;
  localparam logic [7:0] OFF_AGR_DELAY = 8'h20;
  localparam logic [7:0] OFF_TRQ_LVL   = 8'h24;
  localparam logic [7:0] OFF_OL_LVL    = 8'h28;
  localparam logic [7:0] OFF_MAX_SPEED = 8'h2C;
  localparam logic [7:0] OFF_STATUS    = 8'h30;
  localparam logic [7:0] OFF_COMM      = 8'h34;

  // Field positions inside the selection registers.
  localparam int SEL_LO_POS = 0;
  localparam int SEL_HI_POS = 8;

  // Reset values.
  localparam logic [7:0]  RST_SEL_A     = 8'h00;
  localparam logic [7:0]  RST_SEL_B     = 8'h05;
  localparam logic [7:0]  RST_SEL_C     = 8'h06;
  localparam logic [7:0]  RST_SEL_R     = 8'h04;
  localparam logic [13:0] RST_SPD_LVL1  = 14'h0064;
  localparam logic [15:0] RST_SPD_LVL2  = 16'h0064;
  localparam logic [15:0] RST_SPD_LVL3  = 16'h0064;
  localparam logic [3:0]  RST_METHOD    = 4'h0;
  localparam logic [7:0]  RST_ARR_WIDTH = 8'h0A;
  localparam logic [7:0]  RST_AGR_WIDTH = 8'h0A;
  localparam logic [9:0]  RST_AGR_DELAY = 10'h000;
  localparam logic [11:0] RST_TRQ_LVL   = 12'h3E8;
  localparam logic [6:0]  RST_OL_LVL    = 7'h50;
  localparam logic [13:0] RST_MAX_SPEED = 14'h05DC;

  // Selection codes and limits.
  localparam logic [7:0]  CODE_MAX      = 8'h12;
  localparam int          NUM_CODES     = 19;
  localparam logic [6:0]  OL_FULL       = 7'h64;
  localparam logic [15:0] WIDTH_SCALE   = 16'h03E8;

  // Timing: control clock and off-delay unit.
  localparam int CLK_HZ        = 40000000;
  localparam int DELAY_UNIT_MS = 1;
  localparam int CYCLES_PER_MS = CLK_HZ / 1000 * DELAY_UNIT_MS;

  // Flag index of each selection code.
  localparam int F_DCLINK = 0;
  localparam int F_RUN    = 1;
  localparam int F_ACC    = 2;
  localparam int F_DEC    = 3;
  localparam int F_NZS    = 4;
  localparam int F_ARR    = 5;
  localparam int F_AGR    = 6;
  localparam int F_TH1    = 7;
  localparam int F_TH2    = 8;
  localparam int F_TH3    = 9;
  localparam int F_TLIM   = 10;
  localparam int F_TRQ    = 11;
  localparam int F_OL     = 12;
  localparam int F_MOH    = 13;
  localparam int F_MOL    = 14;
  localparam int F_BRS    = 15;
  localparam int F_BRK    = 16;
  localparam int F_CDO    = 17;
  localparam int F_CERR   = 18;

  // Speed signals that the comparators use.
  typedef struct packed {
    logic signed [15:0] speed_feedback;
    logic signed [15:0] post_ramp_speed_setting;
    logic signed [15:0] ramp_input_setpoint;
    logic signed [15:0] updown_adjuster_output;
    logic signed [15:0] aux_speed_setting_two;
    logic signed [15:0] speed_bias;
  } dso_speed_s;

  // Protection and drive state levels.
  typedef struct packed {
    logic       dclink_not_under_uv;
    logic       inverter_running;
    logic       speed_exists;
    logic       torque_limited;
    logic       motor_overheat_warning;
    logic       motor_overload_warning;
    logic       inverter_overload_trip;
    logic       comm_error;
    logic       speed_limit_active;
    logic       updown_mode;
    logic [6:0] overload_percent;
  } dso_state_s;

endpackage

//--- hdl/dso_status_out.sv
// Purpose: Drive status flags, their comparators, and the four selectable output terminals.
// Assumes: All inputs come from logic on the same control clock; no synchronisers needed.
// Notes:   Registers reached over APB with zero wait states; flags and outputs are registered.
//
// Chosen here: the APB interface to the registers and the register addresses.
module dso_status_out #(
  parameter int CYCLES_PER_MS = dso_pkg::CYCLES_PER_MS
) (
  input  wire logic               clock,
  input  wire logic               reset_n,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire dso_pkg::dso_speed_s speeds,
  input  wire dso_pkg::dso_state_s state,
  input  wire logic signed [15:0] torque_command,
  output logic                    transistor_out_a,
  output logic                    transistor_out_b,
  output logic                    transistor_out_c,
  output logic                    relay_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions.

  // Magnitude of a signed speed or torque.
  function automatic logic [15:0] mag(input logic signed [15:0] x);
    mag = x[15] ? 16'(-x) : 16'(x);
  endfunction

  // Band in rpm from a width in tenths of a percent of maximum speed.
  function automatic logic [15:0] band(input logic [7:0] w, input logic [13:0] mx);
    logic [21:0] p;
    p = 22'(w) * 22'(mx);
    band = 16'(p / 22'(dso_pkg::WIDTH_SCALE));
  endfunction

  // True while a lies within plus or minus b of c.
  function automatic logic in_band(input logic signed [15:0] a, input logic signed [15:0] c,
                                   input logic [15:0] b);
    logic signed [16:0] d;
    logic [16:0]        m;
    d = 17'(a) - 17'(c);
    m = d[16] ? 17'(-d) : 17'(d);
    in_band = (m <= 17'(b));
  endfunction

  // Flag picked by a selection code; unused codes give zero.
  function automatic logic pick(input logic [7:0] code, input logic [18:0] f);
    pick = (code <= dso_pkg::CODE_MAX) ? f[code[4:0]] : 1'b0;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers.

  logic        [7:0]  sel_a_q;
  logic        [7:0]  sel_b_q;
  logic        [7:0]  sel_c_q;
  logic        [7:0]  sel_r_q;
  logic        [13:0] lvl1_q;
  logic signed [15:0] lvl2_q;
  logic signed [15:0] lvl3_q;
  logic        [3:0]  method_q;
  logic        [7:0]  arr_w_q;
  logic        [7:0]  agr_w_q;
  logic        [9:0]  agr_dly_q;
  logic        [11:0] trq_lvl_q;
  logic        [6:0]  ol_lvl_q;
  logic        [13:0] max_spd_q;
  logic               comm_do_q;
  logic        [18:0] flags_q;
  logic               wr_en;
  logic               known;

  assign wr_en   = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !known;

  // Software writes to the configuration registers.
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sel_a_q   <= dso_pkg::RST_SEL_A;
      sel_b_q   <= dso_pkg::RST_SEL_B;
      sel_c_q   <= dso_pkg::RST_SEL_C;
      sel_r_q   <= dso_pkg::RST_SEL_R;
      lvl1_q    <= dso_pkg::RST_SPD_LVL1;
      lvl2_q    <= dso_pkg::RST_SPD_LVL2;
      lvl3_q    <= dso_pkg::RST_SPD_LVL3;
      method_q  <= dso_pkg::RST_METHOD;
      arr_w_q   <= dso_pkg::RST_ARR_WIDTH;
      agr_w_q   <= dso_pkg::RST_AGR_WIDTH;
      agr_dly_q <= dso_pkg::RST_AGR_DELAY;
      trq_lvl_q <= dso_pkg::RST_TRQ_LVL;
      ol_lvl_q  <= dso_pkg::RST_OL_LVL;
      max_spd_q <= dso_pkg::RST_MAX_SPEED;
      comm_do_q <= 1'b0;
    end
    else if (wr_en)
    begin
      unique case (paddr)
        dso_pkg::OFF_SEL_AB:
        begin
          sel_a_q <= pwdata[dso_pkg::SEL_LO_POS +: 8];
          sel_b_q <= pwdata[dso_pkg::SEL_HI_POS +: 8];
        end
        dso_pkg::OFF_SEL_CR:
        begin
          sel_c_q <= pwdata[dso_pkg::SEL_LO_POS +: 8];
          sel_r_q <= pwdata[dso_pkg::SEL_HI_POS +: 8];
        end
        dso_pkg::OFF_SPD_LVL1:  lvl1_q    <= pwdata[13:0];
        dso_pkg::OFF_SPD_LVL2:  lvl2_q    <= pwdata[15:0];
        dso_pkg::OFF_SPD_LVL3:  lvl3_q    <= pwdata[15:0];
        dso_pkg::OFF_METHOD:    method_q  <= pwdata[3:0];
        dso_pkg::OFF_ARR_WIDTH: arr_w_q   <= pwdata[7:0];
        dso_pkg::OFF_AGR_WIDTH: agr_w_q   <= pwdata[7:0];
        dso_pkg::OFF_AGR_DELAY: agr_dly_q <= pwdata[9:0];
        dso_pkg::OFF_TRQ_LVL:   trq_lvl_q <= pwdata[11:0];
        dso_pkg::OFF_OL_LVL:    ol_lvl_q  <= pwdata[6:0];
        dso_pkg::OFF_MAX_SPEED: max_spd_q <= pwdata[13:0];
        dso_pkg::OFF_COMM:      comm_do_q <= pwdata[0];
        default:                ;
      endcase
    end
  end

  // Read decode; the status word shows the registered flags.
  always_comb
  begin
    known  = 1'b1;
    prdata = 32'h0000_0000;
    unique case (paddr)
      dso_pkg::OFF_SEL_AB:    prdata = {16'h0000, sel_b_q, sel_a_q};
      dso_pkg::OFF_SEL_CR:    prdata = {16'h0000, sel_r_q, sel_c_q};
      dso_pkg::OFF_SPD_LVL1:  prdata = {18'h00000, lvl1_q};
      dso_pkg::OFF_SPD_LVL2:  prdata = {16'h0000, lvl2_q};
      dso_pkg::OFF_SPD_LVL3:  prdata = {16'h0000, lvl3_q};
      dso_pkg::OFF_METHOD:    prdata = {28'h0000000, method_q};
      dso_pkg::OFF_ARR_WIDTH: prdata = {24'h000000, arr_w_q};
      dso_pkg::OFF_AGR_WIDTH: prdata = {24'h000000, agr_w_q};
      dso_pkg::OFF_AGR_DELAY: prdata = {22'h000000, agr_dly_q};
      dso_pkg::OFF_TRQ_LVL:   prdata = {20'h00000, trq_lvl_q};
      dso_pkg::OFF_OL_LVL:    prdata = {25'h0000000, ol_lvl_q};
      dso_pkg::OFF_MAX_SPEED: prdata = {18'h00000, max_spd_q};
      dso_pkg::OFF_STATUS:    prdata = {9'h000, relay_out, transistor_out_c, transistor_out_b,
                                        transistor_out_a, flags_q};
      dso_pkg::OFF_COMM:      prdata = {31'h00000000, comm_do_q};
      default:                known  = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Comparators.

  logic signed [15:0] spd_th1;
  logic signed [15:0] spd_th2;
  logic signed [15:0] spd_th3;
  logic signed [15:0] lim2;
  logic signed [15:0] lim3;
  logic        [13:0] lim1;
  logic               th1;
  logic               th2;
  logic               th3;
  logic               arrival;
  logic               agree_in;
  logic               trq_over;
  logic               ol_warn;
  logic               braking;
  logic               suppress;
  logic               acc_raw;
  logic               dec_raw;
  logic signed [15:0] adj_prev_q;

  // Compared speed per detector: feedback for digit 0, command for digit 1.
  assign spd_th1 = method_q[1] ? speeds.post_ramp_speed_setting : speeds.speed_feedback;
  assign spd_th2 = method_q[2] ? speeds.post_ramp_speed_setting : speeds.speed_feedback;
  assign spd_th3 = method_q[3] ? speeds.post_ramp_speed_setting : speeds.speed_feedback;

  // Levels at or above the maximum speed compare as the maximum speed.
  assign lim1 = (lvl1_q >= max_spd_q) ? max_spd_q : lvl1_q;
  assign lim2 = (lvl2_q >= $signed({2'b00, max_spd_q})) ? $signed({2'b00, max_spd_q}) : lvl2_q;
  assign lim3 = (lvl3_q >= $signed({2'b00, max_spd_q})) ? $signed({2'b00, max_spd_q}) : lvl3_q;

  assign th1 = mag(spd_th1) > {2'b00, lim1};
  assign th2 = spd_th2 > lim2;
  assign th3 = spd_th3 > lim3;

  // Arrival and agreement bands scale with the maximum speed.
  assign arrival  = in_band(speeds.speed_feedback, speeds.ramp_input_setpoint,
                            band(arr_w_q, max_spd_q));
  assign agree_in = in_band(speeds.speed_feedback, speeds.post_ramp_speed_setting,
                            band(agr_w_q, max_spd_q));

  assign trq_over = mag(torque_command) > {4'h0, trq_lvl_q};

  // Warning once the overload accumulation reaches the level; at full level it equals the trip.
  assign ol_warn = (ol_lvl_q >= dso_pkg::OL_FULL) ? state.inverter_overload_trip
                                                   : (state.overload_percent >= ol_lvl_q);

  // Zero counts as positive on both signs.
  assign braking = torque_command[15] != speeds.speed_feedback[15];

  // Aux setting, bias or an active speed limit leave no valid ramp judgement.
  assign suppress = (speeds.aux_speed_setting_two != 16'sh0000) || (speeds.speed_bias != 16'sh0000) ||
                    state.speed_limit_active;

  // Direction judgement from the adjuster or from setpoint against feedback.
  always_comb
  begin
    acc_raw = 1'b0;
    dec_raw = 1'b0;
    if (state.updown_mode)
    begin
      acc_raw = speeds.updown_adjuster_output > adj_prev_q;
      dec_raw = speeds.updown_adjuster_output < adj_prev_q;
    end
    else if (!arrival)
    begin
      acc_raw = mag(speeds.ramp_input_setpoint) > mag(speeds.speed_feedback);
      dec_raw = mag(speeds.ramp_input_setpoint) < mag(speeds.speed_feedback);
    end
    if (suppress)
    begin
      acc_raw = 1'b0;
      dec_raw = 1'b0;
    end
  end

  // Previous adjuster output for the direction test.
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      adj_prev_q <= 16'sh0000;
    else
      adj_prev_q <= speeds.updown_adjuster_output;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Agreement off-delay.

  logic [31:0] tick_cnt_q;
  logic [9:0]  ms_cnt_q;
  logic        agree_q;
  logic        tick;

  assign tick = (tick_cnt_q == 32'(CYCLES_PER_MS - 1));

  // Runs the millisecond timer only while the flag is on and speed is out of band.
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tick_cnt_q <= 32'h0000_0000;
      ms_cnt_q   <= 10'h000;
      agree_q    <= 1'b0;
    end
    else if (agree_in)
    begin
      tick_cnt_q <= 32'h0000_0000;
      ms_cnt_q   <= 10'h000;
      agree_q    <= 1'b1;
    end
    else if (agree_q)
    begin
      if (ms_cnt_q >= agr_dly_q)
        agree_q <= 1'b0;
      else if (tick)
      begin
        tick_cnt_q <= 32'h0000_0000;
        ms_cnt_q   <= ms_cnt_q + 10'h001;
      end
      else
        tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Brake release.

  logic brs_q;

  // Released once torque passes its level; applied when speed drops below level one or on stop.
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      brs_q <= 1'b0;
    else if (!state.inverter_running)
      brs_q <= 1'b0;
    else if (trq_over)
      brs_q <= 1'b1;
    else if (flags_q[dso_pkg::F_TH1] && !th1)
      brs_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flag register and output multiplexers.

  logic [18:0] flags_d;

  // Flag vector indexed by selection code.
  always_comb
  begin
    flags_d                   = '0;
    flags_d[dso_pkg::F_DCLINK] = state.dclink_not_under_uv;
    flags_d[dso_pkg::F_RUN]    = state.inverter_running;
    flags_d[dso_pkg::F_ACC]    = acc_raw;
    flags_d[dso_pkg::F_DEC]    = dec_raw;
    flags_d[dso_pkg::F_NZS]    = state.speed_exists;
    flags_d[dso_pkg::F_ARR]    = arrival;
    flags_d[dso_pkg::F_AGR]    = agree_in || agree_q;
    flags_d[dso_pkg::F_TH1]    = th1;
    flags_d[dso_pkg::F_TH2]    = th2;
    flags_d[dso_pkg::F_TH3]    = th3;
    flags_d[dso_pkg::F_TLIM]   = state.torque_limited;
    flags_d[dso_pkg::F_TRQ]    = trq_over;
    flags_d[dso_pkg::F_OL]     = ol_warn;
    flags_d[dso_pkg::F_MOH]    = state.motor_overheat_warning;
    flags_d[dso_pkg::F_MOL]    = state.motor_overload_warning;
    flags_d[dso_pkg::F_BRS]    = brs_q;
    flags_d[dso_pkg::F_BRK]    = braking;
    flags_d[dso_pkg::F_CDO]    = comm_do_q;
    flags_d[dso_pkg::F_CERR]   = state.comm_error;
  end

  // Flags are sampled every cycle.
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      flags_q <= '0;
    else
      flags_q <= flags_d;
  end

  // Each terminal picks its own flag; the same code gives the same signal.
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      transistor_out_a <= 1'b0;
      transistor_out_b <= 1'b0;
      transistor_out_c <= 1'b0;
      relay_out        <= 1'b0;
    end
    else
    begin
      transistor_out_a <= pick(sel_a_q, flags_q);
      transistor_out_b <= pick(sel_b_q, flags_q);
      transistor_out_c <= pick(sel_c_q, flags_q);
      relay_out        <= pick(sel_r_q, flags_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  // Speed in band for one cycle, then out of band for the next two.
  sequence s_left_band;
    agree_in ##1 !agree_in [*2];
  endsequence

  a_out_a_select: assert property (@(posedge clock) disable iff (!reset_n)
    ##1 transistor_out_a == pick($past(sel_a_q), $past(flags_q)))
    else $error("Output a does not follow its code.");

  a_relay_select: assert property (@(posedge clock) disable iff (!reset_n)
    (sel_r_q > dso_pkg::CODE_MAX) |=> !relay_out)
    else $error("Relay driven by an unused code.");

  a_same_code: assert property (@(posedge clock) disable iff (!reset_n)
    (sel_a_q == sel_c_q) |=> (transistor_out_a == transistor_out_c))
    else $error("Outputs with one code differ.");

  a_th1_level: assert property (@(posedge clock) disable iff (!reset_n)
    (mag(spd_th1) > {2'b00, max_spd_q}) |=> flags_q[dso_pkg::F_TH1])
    else $error("Threshold one missed above maximum speed.");

  a_th2_level: assert property (@(posedge clock) disable iff (!reset_n)
    (spd_th2 <= lim2) |=> !flags_q[dso_pkg::F_TH2])
    else $error("Threshold two set at or below its level.");

  a_agree_hold: assert property (@(posedge clock) disable iff (!reset_n)
    (s_left_band ##0 (agr_dly_q != 10'h000)) |-> flags_d[dso_pkg::F_AGR])
    else $error("Agreement dropped before its off-delay.");

  a_agree_zero: assert property (@(posedge clock) disable iff (!reset_n)
    (agr_dly_q == 10'h000 && !agree_in)[*2] |=> !flags_q[dso_pkg::F_AGR])
    else $error("Agreement stayed on with no off-delay.");

  a_ramp_suppr: assert property (@(posedge clock) disable iff (!reset_n)
    suppress |=> !flags_q[dso_pkg::F_ACC] && !flags_q[dso_pkg::F_DEC])
    else $error("Ramp flag set while suppressed.");

  a_brake_sign: assert property (@(posedge clock) disable iff (!reset_n)
    ##1 flags_q[dso_pkg::F_BRK] == ($past(torque_command[15]) ^ $past(speeds.speed_feedback[15])))
    else $error("Braking flag does not match signs.");

  a_run_flag: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(state.inverter_running) |=> flags_q[dso_pkg::F_RUN] ##1 (sel_b_q != 8'h01 || transistor_out_b))
    else $error("Running flag or its output late.");

endmodule

//--- test/dso_terminal_model.sv
// Purpose: Far-side load on the four status terminals, such as relays and lamps.
// Assumes: Terminals are active-high levels on the control clock.
// Notes:   Each load follows its terminal one clock late, as a relay coil would.
module dso_terminal_model (
  input  wire logic       clock,
  input  wire logic [3:0] terminals,
  output logic      [3:0] seen
);
  timeunit 1ns;
  timeprecision 100ps;

  // Latch what each terminal shows.
  always_ff @(posedge clock)
  begin
    seen <= terminals;
  end
endmodule

//--- test/dso_status_out_bench.sv
// Purpose: Self-checking bench for the drive status output logic.
// Assumes: APB slave answers with pready; terminals lag their inputs by a few clocks.
// Notes:   An integer model predicts every terminal from its code and the inputs, except code 15 (brake release), which only the brake release test checks.
module dso_status_out_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int CPM = 4;
  logic                clock = 1'b0;
  logic                reset_n = 1'b0;
  logic                psel = 1'b0;
  logic                penable = 1'b0;
  logic                pwrite = 1'b0;
  logic [7:0]          paddr = 8'h00;
  logic [31:0]         pwdata = 32'h0;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  dso_pkg::dso_speed_s speeds = '0;
  dso_pkg::dso_state_s state = '0;
  logic signed [15:0]  torque_command = 16'sh0;
  logic [3:0]          outs;
  logic [3:0]          seen;
  logic [31:0]         rd;
  logic                err;
  int                  fail_count = 0;
  int                  tests_run = 0;
  int                  lvl[3];
  int                  code[4];
  int                  comm = 0;
  int                  meth = 0;
  int                  base = 0;

  // Clock at 40 MHz.
  always #12.5 clock = ~clock;

  dso_status_out #(.CYCLES_PER_MS(CPM)) u_dso_status_out (
    .clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .speeds(speeds), .state(state), .torque_command(torque_command),
    .transistor_out_a(outs[0]), .transistor_out_b(outs[1]), .transistor_out_c(outs[2]), .relay_out(outs[3]));
  dso_terminal_model u_dso_terminal_model (.clock(clock), .terminals(outs), .seen(seen));

  ////////////////////////////////////////////////////////////////////////////////
  // One APB transfer; the request is held until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1)
    begin
      @(posedge clock);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Compare and count.
  task automatic check(input string what, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, s);
    end
  endtask

  // Ends the run with the verdict.
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  function automatic int mag(input int x);
    return (x < 0) ? -x : x;
  endfunction

  // Speed seen by threshold detector b: feedback or command.
  function automatic int sp(input int b);
    return meth[b] ? int'(speeds.post_ramp_speed_setting) : int'(speeds.speed_feedback);
  endfunction

  // Reference model of one terminal, maximum speed 1500 and band 15 rpm.
  function automatic logic model(input int c);
    int fb;
    int t;
    int ri;
    fb = speeds.speed_feedback;
    t = torque_command;
    ri = speeds.ramp_input_setpoint;
    case (c)
      0: return state.dclink_not_under_uv;
      1: return state.inverter_running;
      2: return !state.speed_limit_active && !state.updown_mode && mag(fb - ri) > 15 && mag(ri) > mag(fb);
      3: return !state.speed_limit_active && !state.updown_mode && mag(fb - ri) > 15 && mag(ri) < mag(fb);
      4: return state.speed_exists;
      5: return mag(fb - speeds.ramp_input_setpoint) <= 15;
      6: return mag(fb - speeds.post_ramp_speed_setting) <= 15;
      7: return mag(sp(1)) > ((lvl[0] < 1500) ? lvl[0] : 1500);
      8: return sp(2) > ((lvl[1] < 1500) ? lvl[1] : 1500);
      9: return sp(3) > ((lvl[2] < 1500) ? lvl[2] : 1500);
      10: return state.torque_limited;
      11: return mag(t) > 1000;
      12: return state.overload_percent >= 80;
      13: return state.motor_overheat_warning;
      14: return state.motor_overload_warning;
      16: return (t < 0) != (fb < 0);
      17: return comm[0];
      18: return state.comm_error;
      default: return 1'b0;
    endcase
  endfunction

  // Moves feedback and post-ramp setting, then waits for the terminals.
  task automatic spd(input int f, input int r, input int w);
    @(posedge clock);
    speeds.speed_feedback <= 16'(f);
    speeds.post_ramp_speed_setting <= 16'(r);
    repeat (w) @(posedge clock);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial
  begin
    void'($urandom(32'hBEB346C7));
    repeat (6) @(posedge clock);
    check("terminals in reset", outs, 32'h0);
    reset_n <= 1'b1;
    apb(0, dso_pkg::OFF_SEL_AB, 32'h0);
    check("sel ab reset", rd, 32'h00000500);
    apb(0, dso_pkg::OFF_SEL_CR, 32'h0);
    check("sel cr reset", rd, 32'h00000406);
    apb(0, 8'h38, 32'h0);
    check("unmapped error", err, 32'h1);
    $display("test reset_and_map done");
    for (int i = 0; i < 42; i++)
    begin
      lvl[0] = $urandom_range(2000, 1);
      lvl[1] = int'($urandom_range(4000, 0)) - 2000;
      lvl[2] = int'($urandom_range(4000, 0)) - 2000;
      comm = $urandom_range(1, 0);
      meth = $urandom_range(15, 0);
      code[0] = i % 21;
      for (int k = 1; k < 4; k++)
        code[k] = $urandom_range(20, 0);
      apb(1, dso_pkg::OFF_SPD_LVL1, 32'(lvl[0]));
      apb(1, dso_pkg::OFF_SPD_LVL2, 32'(lvl[1]));
      apb(1, dso_pkg::OFF_SPD_LVL3, 32'(lvl[2]));
      apb(1, dso_pkg::OFF_METHOD, 32'(meth));
      apb(1, dso_pkg::OFF_COMM, 32'(comm));
      apb(1, dso_pkg::OFF_SEL_AB, {16'h0, 8'(code[1]), 8'(code[0])});
      apb(1, dso_pkg::OFF_SEL_CR, {16'h0, 8'(code[3]), 8'(code[2])});
      base = int'($urandom_range(6000, 0)) - 3000;
      @(posedge clock);
      speeds <= {16'(base), 16'(base + int'($urandom_range(40, 0)) - 20),
                 16'(base + int'($urandom_range(40, 0)) - 20), 16'($urandom), 32'h0};
      state <= {10'($urandom), 7'($urandom_range(100, 0))};
      torque_command <= 16'(int'($urandom_range(6000, 0)) - 3000);
      apb(0, dso_pkg::OFF_SPD_LVL1, 32'h0);
      check("level one readback", rd, 32'(lvl[0]));
      repeat (6) @(posedge clock);
      for (int k = 0; k < 4; k++)
        if (code[k] != 15)
          check("terminal", seen[k], model(code[k]));
    end
    $display("test code_matrix done");
    apb(1, dso_pkg::OFF_SEL_CR, 32'h00000606);
    apb(1, dso_pkg::OFF_AGR_DELAY, 32'h3);
    spd(500, 500, 6);
    check("agreement in band", seen[3], 32'h1);
    spd(700, 500, 6);
    check("agreement held", seen[3], 32'h1);
    repeat (20) @(posedge clock);
    check("agreement dropped", seen[3], 32'h0);
    spd(500, 500, 6);
    spd(700, 500, 6);
    spd(505, 500, 1);
    spd(700, 500, 8);
    check("agreement reentry", seen[3], 32'h1);
    repeat (12) @(posedge clock);
    check("agreement dropped again", seen[3], 32'h0);
    $display("test off_delay done");
    apb(1, dso_pkg::OFF_SEL_AB, 32'h0000000F);
    apb(1, dso_pkg::OFF_SPD_LVL1, 32'h00000064);
    @(posedge clock);
    state <= 17'h08000;
    torque_command <= 16'sh05DC;
    spd(500, 500, 6);
    check("brake released", seen[0], 32'h1);
    torque_command <= 16'sh0000;
    spd(500, 500, 6);
    check("brake held", seen[0], 32'h1);
    spd(50, 50, 6);
    check("brake applied", seen[0], 32'h0);
    $display("test brake_release done");
    summarize();
  end

  // Watchdog against a hang.
  initial
  begin
    #(25 * 20000);
    fail_count++;
    summarize();
  end
endmodule
